// ### design/pmc_map.svh
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_BASE_ADDR      32'h40007000
`define PMC_BASE_MASK      32'hfffffff8
`define PMC_OFF_CTL        3'h0
`define PMC_OFF_CS         3'h4

`define PMC_CTL_LP_BIT     0
`define PMC_CTL_STBSEL_BIT 1
`define PMC_CTL_WFC_BIT    2
`define PMC_CTL_SFC_BIT    3
`define PMC_CTL_BKPWEN_BIT 8
`define PMC_CTL_VSEL_LO    14
`define PMC_CTL_VSEL_HI    15
`define PMC_CS_WUF_BIT     0
`define PMC_CS_STANDBY_FLAG_BIT    1
`define PMC_CS_WPEN_BIT    8

`define PMC_VSEL_RST       2'h1
`define PMC_VSEL_LOW       2'h3
`define PMC_BOOT_ADDR      32'h00000000
`define PMC_SYNC_RST       6'h01

`define PMC_CLK_PERIOD_NS  40
`define PMC_POR_HOLD_NS    400
`define PMC_IRC_WAKE_NS    1000
`define PMC_REG_WAKE_NS    2000
`define PMC_POR_HOLD_CYC   ((`PMC_POR_HOLD_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_IRC_WAKE_CYC   ((`PMC_IRC_WAKE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_REG_WAKE_CYC   ((`PMC_REG_WAKE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

// ### design/pmc_pkg.sv
package pmc_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_DEEP,
    ST_DEEP_WAKE,
    ST_STANDBY,
    ST_POWER_UP,
    ST_POR_HOLD
  } pmc_state_t;

  typedef enum logic [1:0] {
    REG_NORMAL,
    REG_LOW_POWER,
    REG_OFF
  } pmc_reg_mode_t;

  typedef struct packed {
    logic core_clk_gate;
    logic domain_clk_stop;
    logic internal_rc_8mhz_off;
    logic internal_rc_48mhz_off;
    logic high_speed_crystal_off;
    logic pll_off;
    logic core_power_off;
    logic io_hiz;
  } pmc_pwr_t;

  typedef struct packed {
    logic reset_pin;
    logic rtc_pin;
    logic low_speed_crystal_pins;
    logic wake_pin;
  } pmc_pin_keep_t;

endpackage : pmc_pkg

// ### design/pmc_top.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "pmc_map.svh"
module pmc_top (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [31:0]           reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  input  wire logic                  core_wait_for_interrupt,
  input  wire logic                  core_wait_for_event,
  input  wire logic                  core_deep_sleep_request,
  input  wire logic                  core_sleep_after_isr,
  input  wire logic                  core_event_on_pending,
  input  wire logic                  core_isr_exit_lowest,
  input  wire logic                  core_irq_any,
  input  wire logic                  core_wake_event,
  input  wire logic                  external_interrupt_ctrl_irq_any,
  input  wire logic                  external_interrupt_ctrl_event_any,
  input  wire logic                  interrupt_pending_any,
  input  wire logic                  pll_enabled,
  input  wire logic                  core_power_good,
  input  wire logic                  external_reset_pin_n,
  input  wire logic                  rtc_alarm,
  input  wire logic                  free_watchdog_reset,
  input  wire logic                  wake_pin,
  input  wire logic                  rtc_pin_cfg,
  input  wire logic                  low_speed_crystal_pin_cfg,
  output pmc_pkg::pmc_pwr_t          pwr,
  output pmc_pkg::pmc_reg_mode_t     regulator_mode,
  output logic [1:0]                 regulator_voltage,
  output logic                       core_rst_n,
  output logic [31:0]                core_boot_addr,
  output logic                       sysclk_internal_rc_8mhz_sel,
  output pmc_pkg::pmc_pin_keep_t     pin_keep,
  output logic                       backup_write_en
);

  pmc_pkg::pmc_state_t     state_reg;
  pmc_pkg::pmc_state_t     state_next;
  logic [5:0]              sync1_reg;
  logic [5:0]              sync2_reg;
  logic                    rst_pin_n_s;
  logic                    rtc_s;
  logic                    wdg_s;
  logic                    wake_s;
  logic                    external_interrupt_ctrl_irq_s;
  logic                    external_interrupt_ctrl_evt_s;
  logic                    wake_arm_reg;
  logic                    wake_trig;
  logic [1:0]              vsel_reg;
  logic                    lp_sel_reg;
  logic                    stb_sel_reg;
  logic                    bkpwen_reg;
  logic                    wake_pin_en_reg;
  logic                    wake_flag_reg;
  logic                    standby_flag_reg;
  logic                    kind_wfe_reg;
  logic [7:0]              cnt_reg;
  logic [7:0]              cnt_next;
  logic                    hit;
  logic                    wr_ctl;
  logic                    wr_cs;
  logic                    entry;
  logic                    entry_wfe;
  logic                    sleep_wake;
  logic                    deep_wake;
  logic                    stby_exit;
  logic                    ctl_reset;
  logic [31:0]             rd_word;
  pmc_pkg::pmc_pwr_t       pwr_next;
  pmc_pkg::pmc_reg_mode_t  mode_next;

  ////////////////////////////////////////////////////////////////////////////
  // Wake input synchronisers

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= `PMC_SYNC_RST;
      sync2_reg <= `PMC_SYNC_RST;
    end else begin
      sync1_reg <= {external_interrupt_ctrl_event_any, external_interrupt_ctrl_irq_any, wake_pin, free_watchdog_reset, rtc_alarm, external_reset_pin_n};
      sync2_reg <= sync1_reg;
    end
  end

  assign rst_pin_n_s = sync2_reg[0];
  assign rtc_s       = sync2_reg[1];
  assign wdg_s       = sync2_reg[2];
  assign wake_s      = sync2_reg[3];
  assign external_interrupt_ctrl_irq_s  = sync2_reg[4];
  assign external_interrupt_ctrl_evt_s  = sync2_reg[5];

  // Enable rising while pin is high counts as an edge too
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_arm_reg <= 1'b0;
    end else begin
      wake_arm_reg <= wake_pin_en_reg & wake_s;
    end
  end

  assign wake_trig = wake_pin_en_reg & wake_s & ~wake_arm_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  assign hit    = (reg_addr & `PMC_BASE_MASK) == `PMC_BASE_ADDR;
  assign wr_ctl = reg_write & hit & (reg_addr[2:0] == `PMC_OFF_CTL);
  assign wr_cs  = reg_write & hit & (reg_addr[2:0] == `PMC_OFF_CS);

  // Control contents are lost with the core domain, so a standby exit clears them
  assign ctl_reset = !reset_n || (state_reg == pmc_pkg::ST_POWER_UP);

  always_ff @(posedge clk) begin
    if (ctl_reset) begin
      vsel_reg    <= `PMC_VSEL_RST;
      lp_sel_reg  <= 1'b0;
      stb_sel_reg <= 1'b0;
      bkpwen_reg  <= 1'b0;
    end else if (wr_ctl) begin
      if (!pll_enabled) begin
        vsel_reg <= reg_wdata[`PMC_CTL_VSEL_HI:`PMC_CTL_VSEL_LO];
      end
      lp_sel_reg  <= reg_wdata[`PMC_CTL_LP_BIT];
      stb_sel_reg <= reg_wdata[`PMC_CTL_STBSEL_BIT];
      bkpwen_reg  <= reg_wdata[`PMC_CTL_BKPWEN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_pin_en_reg <= 1'b0;
    end else if (wr_cs) begin
      wake_pin_en_reg <= reg_wdata[`PMC_CS_WPEN_BIT];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_flag_reg <= 1'b0;
    end else if (wake_trig || rtc_s) begin
      wake_flag_reg <= 1'b1;
    end else if (wr_ctl && reg_wdata[`PMC_CTL_WFC_BIT]) begin
      wake_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      standby_flag_reg <= 1'b0;
    end else if (state_next == pmc_pkg::ST_STANDBY) begin
      standby_flag_reg <= 1'b1;
    end else if (wr_ctl && reg_wdata[`PMC_CTL_SFC_BIT]) begin
      standby_flag_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    if (hit && reg_addr[2:0] == `PMC_OFF_CTL) begin
      rd_word[`PMC_CTL_VSEL_HI:`PMC_CTL_VSEL_LO] = vsel_reg;
      rd_word[`PMC_CTL_BKPWEN_BIT]               = bkpwen_reg;
      rd_word[`PMC_CTL_STBSEL_BIT]               = stb_sel_reg;
      rd_word[`PMC_CTL_LP_BIT]                   = lp_sel_reg;
    end else if (hit && reg_addr[2:0] == `PMC_OFF_CS) begin
      rd_word[`PMC_CS_WPEN_BIT] = wake_pin_en_reg;
      rd_word[`PMC_CS_STANDBY_FLAG_BIT] = standby_flag_reg;
      rd_word[`PMC_CS_WUF_BIT]  = wake_flag_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  assign entry      = core_sleep_after_isr ? core_isr_exit_lowest
                                           : (core_wait_for_interrupt | core_wait_for_event);
  assign entry_wfe  = ~core_sleep_after_isr & core_wait_for_event;
  assign sleep_wake = kind_wfe_reg ? (core_wake_event | (core_event_on_pending & core_irq_any))
                                   : core_irq_any;
  assign deep_wake  = kind_wfe_reg ? (external_interrupt_ctrl_evt_s | (core_event_on_pending & external_interrupt_ctrl_irq_s))
                                   : external_interrupt_ctrl_irq_s;
  assign stby_exit  = ~rst_pin_n_s | rtc_s | wdg_s | wake_trig;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmc_pkg::ST_RUN: begin
        if (entry) begin
          if (!core_deep_sleep_request) begin
            state_next = pmc_pkg::ST_SLEEP;
          end else if (stb_sel_reg) begin
            state_next = pmc_pkg::ST_STANDBY;
          end else if (!interrupt_pending_any) begin
            state_next = pmc_pkg::ST_DEEP;
          end
        end
      end
      pmc_pkg::ST_SLEEP: begin
        if (sleep_wake) begin
          state_next = pmc_pkg::ST_RUN;
        end
      end
      pmc_pkg::ST_DEEP: begin
        if (deep_wake) begin
          state_next = pmc_pkg::ST_DEEP_WAKE;
        end
      end
      pmc_pkg::ST_DEEP_WAKE: begin
        if (cnt_reg == 8'h00) begin
          state_next = pmc_pkg::ST_RUN;
        end
      end
      pmc_pkg::ST_STANDBY: begin
        if (stby_exit) begin
          state_next = pmc_pkg::ST_POWER_UP;
        end
      end
      pmc_pkg::ST_POWER_UP: begin
        if (core_power_good) begin
          state_next = pmc_pkg::ST_POR_HOLD;
        end
      end
      pmc_pkg::ST_POR_HOLD: begin
        if (cnt_reg == 8'h00) begin
          state_next = pmc_pkg::ST_RUN;
        end
      end
      default: state_next = pmc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= pmc_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      kind_wfe_reg <= 1'b0;
    end else if (state_reg == pmc_pkg::ST_RUN && entry) begin
      kind_wfe_reg <= entry_wfe;
    end
  end

  // Latency counter, loaded one below the dwell so the state lasts exactly the count
  always_comb begin
    cnt_next = (cnt_reg == 8'h00) ? 8'h00 : cnt_reg - 8'h01;
    if (state_reg == pmc_pkg::ST_DEEP && state_next == pmc_pkg::ST_DEEP_WAKE) begin
      cnt_next = lp_sel_reg ? 8'(`PMC_IRC_WAKE_CYC + `PMC_REG_WAKE_CYC - 1)
                            : 8'(`PMC_IRC_WAKE_CYC - 1);
    end else if (state_reg == pmc_pkg::ST_POWER_UP && state_next == pmc_pkg::ST_POR_HOLD) begin
      cnt_next = 8'(`PMC_POR_HOLD_CYC - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power controls, decoded from the next state so they line up with state_reg

  always_comb begin
    pwr_next  = '0;
    mode_next = pmc_pkg::REG_NORMAL;
    unique case (state_next)
      pmc_pkg::ST_SLEEP: begin
        pwr_next.core_clk_gate = 1'b1;
      end
      pmc_pkg::ST_DEEP: begin
        pwr_next.core_clk_gate   = 1'b1;
        pwr_next.domain_clk_stop = 1'b1;
        pwr_next.internal_rc_8mhz_off       = 1'b1;
        pwr_next.internal_rc_48mhz_off      = 1'b1;
        pwr_next.high_speed_crystal_off       = 1'b1;
        pwr_next.pll_off         = 1'b1;
        mode_next = lp_sel_reg ? pmc_pkg::REG_LOW_POWER : pmc_pkg::REG_NORMAL;
      end
      pmc_pkg::ST_STANDBY: begin
        pwr_next  = '1;
        mode_next = pmc_pkg::REG_OFF;
      end
      // Clocks held until the oscillator and regulator have settled
      pmc_pkg::ST_POWER_UP, pmc_pkg::ST_DEEP_WAKE: begin
        pwr_next.core_clk_gate   = 1'b1;
        pwr_next.domain_clk_stop = 1'b1;
      end
      pmc_pkg::ST_RUN, pmc_pkg::ST_POR_HOLD: begin
        pwr_next = '0;
      end
      default: pwr_next = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr            <= '0;
      regulator_mode <= pmc_pkg::REG_NORMAL;
    end else begin
      pwr            <= pwr_next;
      regulator_mode <= mode_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regulator_voltage <= `PMC_VSEL_LOW;
    end else begin
      regulator_voltage <= pll_enabled ? vsel_reg : `PMC_VSEL_LOW;
    end
  end

  // Core held in reset through standby, power-up and the hold window
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_rst_n <= 1'b0;
    end else begin
      core_rst_n <= !(state_next == pmc_pkg::ST_STANDBY || state_next == pmc_pkg::ST_POWER_UP
                      || state_next == pmc_pkg::ST_POR_HOLD);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_boot_addr <= `PMC_BOOT_ADDR;
    end else begin
      core_boot_addr <= `PMC_BOOT_ADDR;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sysclk_internal_rc_8mhz_sel <= 1'b0;
    end else begin
      sysclk_internal_rc_8mhz_sel <= (state_reg == pmc_pkg::ST_DEEP) && (state_next == pmc_pkg::ST_DEEP_WAKE);
    end
  end

  // Keep bits only matter while io_hiz is high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_keep <= '1;
    end else if (state_next == pmc_pkg::ST_STANDBY) begin
      pin_keep <= '{reset_pin: 1'b1, rtc_pin: rtc_pin_cfg, low_speed_crystal_pins: low_speed_crystal_pin_cfg,
                    wake_pin: wake_pin_en_reg};
    end else begin
      pin_keep <= '1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      backup_write_en <= 1'b0;
    end else begin
      backup_write_en <= bkpwen_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_sleep_core_only: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_SLEEP |-> pwr.core_clk_gate && !pwr.domain_clk_stop && !pwr.pll_off)
    else $error("sleep gates more than the core clock");

  a_deep_osc_off: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_DEEP |-> pwr.domain_clk_stop && pwr.internal_rc_8mhz_off && pwr.internal_rc_48mhz_off
                                      && pwr.high_speed_crystal_off && pwr.pll_off && !pwr.core_power_off)
    else $error("deep-sleep clocks or oscillators left on");

  a_deep_reg_mode: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_DEEP |->
      regulator_mode == (lp_sel_reg ? pmc_pkg::REG_LOW_POWER : pmc_pkg::REG_NORMAL))
    else $error("deep-sleep regulator mode wrong");

  a_deep_abort_pend: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_RUN && entry && core_deep_sleep_request && !stb_sel_reg
      && interrupt_pending_any |=> state_reg == pmc_pkg::ST_RUN)
    else $error("deep-sleep entered with interrupt pending");

  a_stby_all_off: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_STANDBY |-> pwr.core_power_off && pwr.io_hiz
                                         && regulator_mode == pmc_pkg::REG_OFF && !core_rst_n)
    else $error("standby left power on");

  a_stby_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_STANDBY |-> standby_flag_reg)
    else $error("standby flag not set");

  a_stby_exit_por: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(state_reg == pmc_pkg::ST_STANDBY) |-> state_reg == pmc_pkg::ST_POWER_UP && !core_rst_n
      ##1 !core_rst_n)
    else $error("standby exit without power-on reset");

  a_deep_exit_lat: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == pmc_pkg::ST_DEEP && state_next == pmc_pkg::ST_DEEP_WAKE |=>
      sysclk_internal_rc_8mhz_sel ##0 (state_reg == pmc_pkg::ST_DEEP_WAKE)[*8])
    else $error("deep-sleep exit latency too short");

  a_vsel_pll_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !pll_enabled [*2] |-> regulator_voltage == `PMC_VSEL_LOW)
    else $error("voltage select applied with PLL off");

  a_wake_flag_wins: assert property (@(posedge clk) disable iff (!reset_n)
    wake_trig |=> wake_flag_reg)
    else $error("wake event lost");

endmodule : pmc_top

// ### dv/pmc_core_model.sv
`timescale 1ns/1ns
module pmc_core_model (
  input  wire logic clk,
  output logic      core_wait_for_interrupt,
  output logic      core_wait_for_event,
  output logic      core_deep_sleep_request,
  output logic      core_sleep_after_isr,
  output logic      core_event_on_pending,
  output logic      core_isr_exit_lowest,
  output logic      core_irq_any,
  output logic      core_wake_event
);
  initial begin
    {core_wait_for_interrupt, core_wait_for_event, core_deep_sleep_request, core_sleep_after_isr} = 4'h0;
    {core_event_on_pending, core_isr_exit_lowest, core_irq_any, core_wake_event} = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Mode bits are settled before any wait is issued
  task automatic set_levels(input logic deep, input logic sai, input logic eop);
    core_deep_sleep_request <= deep;
    core_sleep_after_isr    <= sai;
    core_event_on_pending   <= eop;
  endtask : set_levels

  task automatic issue_wait(input logic use_event);
    @(posedge clk);
    core_wait_for_event     <= use_event;
    core_wait_for_interrupt <= !use_event;
    @(posedge clk);
    core_wait_for_event     <= 1'b0;
    core_wait_for_interrupt <= 1'b0;
  endtask : issue_wait

  task automatic set_wake(input logic irq, input logic ev);
    core_irq_any    <= irq;
    core_wake_event <= ev;
  endtask : set_wake

  task automatic isr_return;
    @(posedge clk);
    core_isr_exit_lowest <= 1'b1;
    @(posedge clk);
    core_isr_exit_lowest <= 1'b0;
  endtask : isr_return
endmodule : pmc_core_model

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk, reset_n, reg_write, reg_read, external_interrupt_ctrl_irq_any, external_interrupt_ctrl_event_any;
  logic        interrupt_pending_any, pll_enabled, core_power_good, external_reset_pin_n;
  logic        rtc_alarm, free_watchdog_reset, wake_pin, rtc_pin_cfg, low_speed_crystal_pin_cfg;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, core_boot_addr, d;
  logic        core_wait_for_interrupt, core_wait_for_event, core_deep_sleep_request, core_sleep_after_isr;
  logic        core_event_on_pending, core_isr_exit_lowest, core_irq_any, core_wake_event;
  logic        core_rst_n, sysclk_internal_rc_8mhz_sel, backup_write_en;
  logic [1:0]  regulator_voltage;
  pmc_pkg::pmc_pwr_t      pwr;
  pmc_pkg::pmc_reg_mode_t regulator_mode;
  pmc_pkg::pmc_pin_keep_t pin_keep;
  int          fail_count, n_compared, n;
  localparam logic [31:0] ctl_addr = 32'h40007000;
  localparam logic [31:0] cs_addr  = 32'h40007004;

  pmc_top i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .core_wait_for_interrupt, .core_wait_for_event, .core_deep_sleep_request, .core_sleep_after_isr,
    .core_event_on_pending, .core_isr_exit_lowest, .core_irq_any, .core_wake_event, .external_interrupt_ctrl_irq_any,
    .external_interrupt_ctrl_event_any, .interrupt_pending_any, .pll_enabled, .core_power_good, .external_reset_pin_n,
    .rtc_alarm, .free_watchdog_reset, .wake_pin, .rtc_pin_cfg, .low_speed_crystal_pin_cfg, .pwr, .regulator_mode,
    .regulator_voltage, .core_rst_n, .core_boot_addr, .sysclk_internal_rc_8mhz_sel, .pin_keep, .backup_write_en);
  pmc_core_model i_core (.clk, .core_wait_for_interrupt, .core_wait_for_event, .core_deep_sleep_request,
    .core_sleep_after_isr, .core_event_on_pending, .core_isr_exit_lowest, .core_irq_any, .core_wake_event);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wake(input logic irq, input logic ev, input logic [7:0] exp);
    @(posedge clk);
    i_core.set_wake(irq, ev);
    repeat (3) @(posedge clk);
    #1 chk(32'(pwr), 32'(exp));
    @(posedge clk);
    i_core.set_wake(1'b0, 1'b0);
  endtask : wake
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(pwr), 32'h0);
    chk(32'(regulator_mode), 32'(pmc_pkg::REG_NORMAL));
    chk({core_rst_n, pin_keep}, 32'h1f);
    rd(ctl_addr, d);
    chk(d, 32'h4000);
    rd(cs_addr, d);
    chk(d, 32'h0);
    rd(32'h40007008, d);
    chk(d, 32'h0);
  endtask : t_reset

  task automatic t_vsel;
    wr(ctl_addr, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(32'(regulator_voltage), 32'h3);
    @(posedge clk);
    pll_enabled <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(32'(regulator_voltage), 32'h0);
    wr(ctl_addr, 32'hc100);
    rd(ctl_addr, d);
    chk(d, 32'h100);
    chk(32'(backup_write_en), 32'h1);
    @(posedge clk);
    pll_enabled <= 1'b0;
    wr(ctl_addr, 32'h4000);
  endtask : t_vsel

  task automatic t_sleep;
    i_core.issue_wait(1'b0);
    #1 chk(32'(pwr), 32'h80);
    wake(1'b1, 1'b0, 8'h00);
    i_core.issue_wait(1'b1);
    wake(1'b1, 1'b0, 8'h80);
    wake(1'b0, 1'b1, 8'h00);
    i_core.set_levels(1'b0, 1'b0, 1'b1);
    i_core.issue_wait(1'b1);
    wake(1'b1, 1'b0, 8'h00);
    i_core.set_levels(1'b0, 1'b1, 1'b0);
    i_core.issue_wait(1'b0);
    #1 chk(32'(pwr), 32'h0);
    i_core.isr_return();
    #1 chk(32'(pwr), 32'h80);
    wake(1'b1, 1'b0, 8'h00);
    i_core.set_levels(1'b0, 1'b0, 1'b0);
  endtask : t_sleep

  // Low-power regulator pass uses the event path, normal pass the interrupt path
  task automatic t_deep;
    for (int lp = 0; lp < 2; lp++) begin
      wr(ctl_addr, 32'(32'h4000 + lp));
      i_core.set_levels(1'b1, 1'b0, 1'b0);
      interrupt_pending_any <= 1'b1;
      i_core.issue_wait(lp[0]);
      repeat (2) @(posedge clk);
      #1 chk(32'(pwr), 32'h0);
      @(posedge clk);
      interrupt_pending_any <= 1'b0;
      repeat (2) @(posedge clk);
      i_core.issue_wait(lp[0]);
      repeat (2) @(posedge clk);
      #1 chk(32'(pwr[6:2]), 32'h1f);
      chk(32'(regulator_mode), lp ? 32'(pmc_pkg::REG_LOW_POWER) : 32'(pmc_pkg::REG_NORMAL));
      wake(1'b1, 1'b1, 8'hfc);
      @(posedge clk);
      external_interrupt_ctrl_irq_any   <= !lp[0];
      external_interrupt_ctrl_event_any <= lp[0];
      for (n = 0; n < 8 && sysclk_internal_rc_8mhz_sel !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      chk(32'(sysclk_internal_rc_8mhz_sel), 32'h1);
      chk(32'(pwr), 32'hc0);
      for (n = 0; n < 150 && pwr !== 8'h0; n++) begin
        @(posedge clk);
        #1;
      end
      chk(n, lp ? 32'd75 : 32'd25);
      external_interrupt_ctrl_irq_any   <= 1'b0;
      external_interrupt_ctrl_event_any <= 1'b0;
      chk(32'(pwr), 32'h0);
    end
    i_core.set_levels(1'b0, 1'b0, 1'b0);
  endtask : t_deep

  task automatic t_standby(input logic [1:0] src);
    @(posedge clk);
    rtc_pin_cfg   <= src[0];
    low_speed_crystal_pin_cfg <= src[1];
    wr(cs_addr, 32'h100);
    wr(ctl_addr, 32'h4006);
    i_core.set_levels(1'b1, 1'b0, 1'b0);
    i_core.issue_wait(1'b0);
    #1 chk(32'(pwr[1:0]), 32'h3);
    chk(32'(regulator_mode), 32'(pmc_pkg::REG_OFF));
    chk(32'(pin_keep), {28'h0, 1'b1, src[0], src[1], 1'b1});
    @(posedge clk);
    i_core.set_levels(1'b0, 1'b0, 1'b0);
    core_power_good <= 1'b0;
    case (src)
      2'h0: external_reset_pin_n <= 1'b0;
      2'h1: rtc_alarm <= 1'b1;
      2'h2: free_watchdog_reset <= 1'b1;
      default: wake_pin <= 1'b1;
    endcase
    for (n = 0; n < 10 && pwr !== 8'hc0; n++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(pwr), 32'hc0);
    chk(32'(core_rst_n), 32'h0);
    @(posedge clk);
    {external_reset_pin_n, rtc_alarm, free_watchdog_reset, wake_pin} <= 4'h8;
    core_power_good <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(32'(core_rst_n), 32'h0);
    for (n = 0; n < 8 && core_rst_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(core_rst_n), 32'h1);
    chk(core_boot_addr, 32'h0);
    rd(cs_addr, d);
    chk(32'(d[1]), 32'h1);
    rd(ctl_addr, d);
    chk(d, 32'h4000);
    wr(ctl_addr, 32'h4008);
    rd(cs_addr, d);
    chk(32'(d[1]), 32'h0);
  endtask : t_standby
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this is ten thousand
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    {reset_n, reg_write, reg_read, external_interrupt_ctrl_irq_any, external_interrupt_ctrl_event_any, interrupt_pending_any} = 6'h0;
    {pll_enabled, rtc_alarm, free_watchdog_reset, wake_pin, rtc_pin_cfg, low_speed_crystal_pin_cfg} = 6'h0;
    {core_power_good, external_reset_pin_n, reg_addr, reg_wdata, fail_count, n_compared} = '0;
    core_power_good      = 1'b1;
    external_reset_pin_n = 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 t_reset();
    t_vsel();
    t_sleep();
    t_deep();
    for (int s = 0; s < 4; s++) t_standby(2'(s));
    complete_run();
  end
endmodule : testbench
